// ==== bfx_pkg.sv ====
// Package of constants and types for the bit-invert and flag-branch executor
// ----------------------------------------------------------------------------
// What this block does
// ----------------------------------------------------------------------------
// What this block does
// - Bit-invert opcode 0111, then bit number, access flag, file address.
// - Bit-invert flips only the selected bit of the addressed location.
// - Access flag 0 selects the access bank, ignoring the bank select register.
// - Access flag 1 forms address from bank select register plus file address.
// - Branch-on-overflow upper byte is 1110 0100, signed offset below.
// - Branch-on-overflow branches only when overflow flag is set.
// - Branch-on-zero upper byte is 1110 0000, signed offset below.
// - Branch-on-zero branches only when zero flag is set.
// - Taken target is incremented counter plus twice the signed offset.
// - Branch takes one cycle untaken, two cycles taken.
// - Phases decode, read literal, process, write PC or idle; taken adds idle cycle.
package bfx_pkg;

    localparam logic [3:0]  BIT_INVERT_OPC = 4'h7;
    localparam logic [7:0]  BRANCH_OV_UPPER = 8'hE4;
    localparam logic [7:0]  BRANCH_Z_UPPER  = 8'hE0;
    localparam int          PC_W           = 21;
    localparam int          DADDR_W        = 12;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [PC_W-1:0] PC_RESET   = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP    = 21'h000002;

    typedef enum logic [1:0] {
        BFX_Q1,
        BFX_Q2,
        BFX_Q3,
        BFX_Q4
    } bfx_phase_e;

    typedef enum logic [1:0] {
        BFX_OP_NONE,
        BFX_OP_INVERT,
        BFX_OP_BRANCH_OV,
        BFX_OP_BRANCH_Z
    } bfx_op_e;

    typedef struct packed {
        bfx_op_e      op;
        logic [2:0]   bit_num;
        logic         access_sel;
        logic [7:0]   lit;
    } bfx_dec_s;

    typedef struct packed {
        logic               we;
        logic [DADDR_W-1:0] addr;
        logic [7:0]         wdata;
    } bfx_dwr_s;

endpackage

// ==== bfx_decode.sv ====
// Opcode field decoder
`timescale 1ns/1ns
module bfx_decode
    import bfx_pkg::*;
(
    input  wire logic [15:0]       instr,
    output bfx_pkg::bfx_dec_s      dec
);
    always_comb
    begin
        dec            = '0;
        dec.lit        = instr[7:0];
        dec.bit_num    = instr[11:9];
        dec.access_sel = instr[8];
        if (instr[15:12] == BIT_INVERT_OPC)
        begin
            dec.op = BFX_OP_INVERT;
        end
        else if (instr[15:8] == BRANCH_OV_UPPER)
        begin
            dec.op = BFX_OP_BRANCH_OV;
        end
        else if (instr[15:8] == BRANCH_Z_UPPER)
        begin
            dec.op = BFX_OP_BRANCH_Z;
        end
        else
        begin
            dec.op = BFX_OP_NONE;
        end
    end
endmodule

// ==== bfx_addr.sv ====
// Banked versus access-bank operand address former
`timescale 1ns/1ns
module bfx_addr
    import bfx_pkg::*;
(
    input  wire logic [7:0]              file_addr,
    input  wire logic                    access_sel,
    input  wire logic [3:0]              bank,
    output logic [bfx_pkg::DADDR_W-1:0]  addr
);
    always_comb
    begin
        if (access_sel)
        begin
            addr = {bank, file_addr};
        end
        else if (file_addr < ACCESS_SPLIT)
        begin
            addr = {ACCESS_LO_BANK, file_addr};
        end
        else
        begin
            addr = {ACCESS_HI_BANK, file_addr};
        end
    end
endmodule

// ==== bfx_exec.sv ====
// Four-phase executor for bit-invert and flag branches
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module bfx_exec
    import bfx_pkg::*;
(
    input  wire logic                       CLK,
    input  wire logic                       NRST,
    input  wire logic                       CE,
    input  wire logic [15:0]                INSTR,
    input  wire logic                       INSTR_VALID,
    input  wire logic [3:0]                 BANK_SELECT_REG,
    input  wire logic                       FLAG_OV,
    input  wire logic                       FLAG_Z,
    input  wire logic [7:0]                 DMEM_RDATA,
    output logic [bfx_pkg::DADDR_W-1:0]     DMEM_ADDR,
    output logic                            DMEM_RE,
    output bfx_pkg::bfx_dwr_s               DMEM_WR,
    output logic [bfx_pkg::PC_W-1:0]        PC,
    output bfx_pkg::bfx_phase_e             PHASE,
    output logic                            STALL_CYCLE,
    output logic                            BUSY_INSTR
);
    import bfx_pkg::*;

    bfx_dec_s             dec;
    bfx_dec_s             cur;
    logic [DADDR_W-1:0]   op_addr;
    logic [7:0]           proc_data;
    logic                 taken;
    logic [PC_W-1:0]      target;

    // ------------------------------------------------------------------------
    // Decode and address
    // ------------------------------------------------------------------------
    bfx_decode u_dec
    (
        .instr (INSTR),
        .dec   (dec)
    );

    bfx_addr u_addr
    (
        .file_addr  (cur.lit),
        .access_sel (cur.access_sel),
        .bank       (BANK_SELECT_REG),
        .addr       (op_addr)
    );

    // ------------------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------------------
    // Phase only advances with CE so the caller can freeze the core
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            PHASE <= BFX_Q1;
        end
        else if (CE)
        begin
            case (PHASE)
                BFX_Q1:  PHASE <= BFX_Q2;
                BFX_Q2:  PHASE <= BFX_Q3;
                BFX_Q3:  PHASE <= BFX_Q4;
                BFX_Q4:  PHASE <= BFX_Q1;
                default: PHASE <= BFX_Q1;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Instruction latch
    // ------------------------------------------------------------------------
    // Decode in Q1
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cur        <= '0;
            BUSY_INSTR <= 1'b0;
        end
        else if (CE && PHASE == BFX_Q1)
        begin
            if (STALL_CYCLE || !INSTR_VALID)
            begin
                cur        <= '0;
                BUSY_INSTR <= 1'b0;
            end
            else
            begin
                cur        <= dec;
                BUSY_INSTR <= (dec.op != BFX_OP_NONE);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Branch condition and target
    // ------------------------------------------------------------------------
    // Overflow and zero flag gate
    assign taken = (cur.op == BFX_OP_BRANCH_OV && FLAG_OV) || (cur.op == BFX_OP_BRANCH_Z && FLAG_Z);

    // PC plus step plus twice offset
    // PC still holds this word here, so the step is added explicitly
    assign target = PC + PC_STEP + {{(PC_W-9){cur.lit[7]}}, cur.lit, 1'b0};

    // ------------------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------------------
    // PC advances past this word only at its own Q4 edge
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            PC <= PC_RESET;
        end
        else if (CE && PHASE == BFX_Q4)
        begin
            if (taken)
            begin
                PC <= target;
            end
            else if (!STALL_CYCLE)
            begin
                PC <= PC + PC_STEP;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Taken-branch idle cycle
    // ------------------------------------------------------------------------
    // Extra cycle when taken
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            STALL_CYCLE <= 1'b0;
        end
        else if (CE && PHASE == BFX_Q4)
        begin
            STALL_CYCLE <= taken;
        end
    end

    // ------------------------------------------------------------------------
    // Bit-invert read-modify-write
    // ------------------------------------------------------------------------
    // Read in Q2
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            DMEM_RE   <= 1'b0;
            DMEM_ADDR <= '0;
        end
        else if (CE)
        begin
            DMEM_RE <= (PHASE == BFX_Q1) && INSTR_VALID && !STALL_CYCLE
                       && dec.op == BFX_OP_INVERT;
            if (PHASE == BFX_Q2 && cur.op == BFX_OP_INVERT)
            begin
                DMEM_ADDR <= op_addr;
            end
        end
    end

    // Read data is sampled in Q3, one cycle after the strobe
    // Flip selected bit
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            proc_data <= '0;
        end
        else if (CE && PHASE == BFX_Q3 && cur.op == BFX_OP_INVERT)
        begin
            proc_data <= DMEM_RDATA ^ (8'h01 << cur.bit_num);
        end
    end

    // Address is computed at Q2 so the read strobe leads it
    // Write in Q4
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            DMEM_WR <= '0;
        end
        else if (CE)
        begin
            DMEM_WR.we <= (PHASE == BFX_Q4) && cur.op == BFX_OP_INVERT;
            if (PHASE == BFX_Q4)
            begin
                DMEM_WR.addr  <= op_addr;
                DMEM_WR.wdata <= proc_data;
            end
        end
    end
endmodule

// ==== bfx_exec_chk.sv ====
// Assertion checker for the bit-invert and flag-branch executor
`timescale 1ns/1ns
module bfx_exec_chk
    import bfx_pkg::*;
(
    input wire logic                     CLK,
    input wire logic                     NRST,
    input wire logic [7:0]               DMEM_RDATA,
    input wire logic [bfx_pkg::DADDR_W-1:0] DMEM_ADDR,
    input wire logic                     DMEM_RE,
    input wire bfx_pkg::bfx_dwr_s        DMEM_WR,
    input wire logic [bfx_pkg::PC_W-1:0] PC,
    input wire bfx_pkg::bfx_phase_e      PHASE,
    input wire logic                     STALL_CYCLE,
    input wire logic                     BUSY_INSTR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    sequence rmw_s;
        PHASE == BFX_Q3 ##1 PHASE == BFX_Q4 ##1 DMEM_WR.we;
    endsequence
    sequence step_s;
        PHASE == BFX_Q4 && !STALL_CYCLE ##1 !STALL_CYCLE;
    endsequence
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_read_phase: assert property (DMEM_RE |-> PHASE == BFX_Q2 && BUSY_INSTR)
        else $error("read strobe outside phase two");
    a_rmw_order: assert property (DMEM_RE |=> rmw_s)
        else $error("read, process, write order broken");
    a_write_addr: assert property (DMEM_RE |-> ##3 DMEM_WR.addr == $past(DMEM_ADDR))
        else $error("write address differs from read address");
    a_one_bit: assert property (DMEM_RE |-> ##3 $countones(DMEM_WR.wdata ^ $past(DMEM_RDATA, 2)) == 1)
        else $error("write data not one bit flipped");
    a_we_pulse: assert property (DMEM_WR.we |=> !DMEM_WR.we)
        else $error("write strobe longer than one cycle");
    a_stall_len: assert property ($rose(STALL_CYCLE) |-> PHASE == BFX_Q1 ##0 STALL_CYCLE[*4] ##1 !STALL_CYCLE)
        else $error("idle cycle not four phases");
    a_stall_hold: assert property (STALL_CYCLE |=> $stable(PC))
        else $error("counter moved in idle cycle");
    a_pc_step: assert property (step_s |-> PC == $past(PC) + PC_STEP)
        else $error("untaken step not two");
endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the bit-invert and flag-branch executor
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
    import bfx_pkg::*;
    logic                CLK, NRST, CE, INSTR_VALID, FLAG_OV, FLAG_Z, DMEM_RE, STALL_CYCLE, BUSY_INSTR;
    logic [15:0]         INSTR, w;
    logic [3:0]          BANK_SELECT_REG;
    logic [7:0]          DMEM_RDATA, lo;
    logic [DADDR_W-1:0]  DMEM_ADDR;
    bfx_dwr_s            DMEM_WR;
    logic [PC_W-1:0]     PC, pc_m, pc_prev;
    bfx_phase_e          PHASE;
    logic [7:0]          mem [0:4095];
    logic [7:0]          ref_m [0:4095];
    logic [19:0]         wq [$];
    logic [19:0]         e;
    logic [PC_W-1:0]     pq [$];
    logic [31:0]         lfsr;
    int                  bad_count, num_checks;
    bfx_exec dut_u (.CLK(CLK), .NRST(NRST), .CE(CE), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
        .BANK_SELECT_REG(BANK_SELECT_REG), .FLAG_OV(FLAG_OV), .FLAG_Z(FLAG_Z), .DMEM_RDATA(DMEM_RDATA),
        .DMEM_ADDR(DMEM_ADDR), .DMEM_RE(DMEM_RE), .DMEM_WR(DMEM_WR), .PC(PC), .PHASE(PHASE),
        .STALL_CYCLE(STALL_CYCLE), .BUSY_INSTR(BUSY_INSTR));
    // Memory reads combinationally, as the executor expects
    assign DMEM_RDATA = mem[DMEM_ADDR];
    initial
    begin
        CLK = 0;
        forever #50 CLK = ~CLK;
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task final_report;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Driver: notes expectations, then waits out the instruction
    // ------------------------------------------------------------------
    task automatic run(input logic [15:0] iw, input logic ov, input logic z, input logic [3:0] bk);
        logic [11:0] a;
        logic        tk;
        INSTR <= iw;
        FLAG_OV <= ov;
        FLAG_Z <= z;
        BANK_SELECT_REG <= bk;
        a = iw[8] ? {bk, iw[7:0]} : {(iw[7:0] < ACCESS_SPLIT ? ACCESS_LO_BANK : ACCESS_HI_BANK), iw[7:0]};
        tk = (iw[15:8] == BRANCH_OV_UPPER && ov) || (iw[15:8] == BRANCH_Z_UPPER && z);
        pc_m = pc_m + PC_STEP + (tk ? {{12{iw[7]}}, iw[7:0], 1'b0} : 21'h000000);
        pq.push_back(pc_m);
        if (iw[15:12] == BIT_INVERT_OPC)
        begin
            ref_m[a] = ref_m[a] ^ (8'h01 << iw[11:9]);
            wq.push_back({a, ref_m[a]});
        end
        // Idle cycle of a taken branch refuses words, so wait it out
        do @(negedge CLK); while (PHASE !== BFX_Q1 || STALL_CYCLE !== 1'b0);
        do @(negedge CLK); while (PHASE !== BFX_Q4);
        @(posedge CLK);
    endtask
    // ------------------------------------------------------------------
    // Monitor: pops the oldest note whenever a result shows
    // ------------------------------------------------------------------
    always @(posedge CLK)
    begin
        if (DMEM_WR.we === 1'b1)
        begin
            mem[DMEM_WR.addr] <= DMEM_WR.wdata;
            e = wq.size() ? wq.pop_front() : 'x;
            `CHK("dmem write", e, {DMEM_WR.addr, DMEM_WR.wdata})
        end
        if (PC !== pc_prev)
        begin
            `CHK("pc", pq.size() ? pq.pop_front() : 'x, PC)
        end
        pc_prev <= PC;
    end
    initial
    begin
        NRST = 0; CE = 1; INSTR = 16'h0000; INSTR_VALID = 1; BANK_SELECT_REG = 4'h0;
        FLAG_OV = 0; FLAG_Z = 0; pc_m = PC_RESET; pc_prev = PC_RESET; lfsr = 32'hB6F8DDF5;
        for (int i = 0; i < 4096; i++)
        begin
            lfsr = nxt(lfsr);
            mem[i] = lfsr[7:0];
            ref_m[i] = lfsr[7:0];
        end
        repeat (5) @(posedge CLK);
        NRST <= 1;
        run(16'h7E7F, 0, 0, 4'h3);
        run(16'h7080, 0, 0, 4'h3);
        run(16'h7080, 0, 0, 4'h3);
        run(16'h7B80, 0, 0, 4'h5);
        run(16'hE480, 1, 0, 4'h0);
        run(16'hE405, 0, 1, 4'h0);
        run(16'hE07F, 0, 1, 4'h0);
        run(16'hE005, 1, 0, 4'h0);
        // Clock enable low must freeze the phase
        CE <= 1'b0;
        repeat (3) @(posedge CLK);
        `CHK("phase frozen", BFX_Q1, PHASE)
        CE <= 1'b1;
        repeat (60)
        begin
            lfsr = nxt(lfsr);
            // Offset minus one leaves the counter still, hiding the update
            lo = (lfsr[23:16] == 8'hFF) ? 8'h00 : lfsr[23:16];
            case (lfsr[1:0])
                2'd0: w = {BIT_INVERT_OPC, lfsr[14:3]};
                2'd1: w = {BRANCH_OV_UPPER, lo};
                2'd2: w = {BRANCH_Z_UPPER, lo};
                default: w = 16'h0000;
            endcase
            run(w, lfsr[24], lfsr[25], lfsr[29:26]);
        end
        repeat (2) @(posedge CLK);
        `CHK("pending", 0, wq.size() + pq.size())
        final_report;
    end
    initial
    begin
        repeat (3000) @(posedge CLK);
        bad_count++;
        final_report;
    end
endmodule
bind bfx_exec bfx_exec_chk chk_u (.CLK(CLK), .NRST(NRST), .DMEM_RDATA(DMEM_RDATA), .DMEM_ADDR(DMEM_ADDR),
    .DMEM_RE(DMEM_RE), .DMEM_WR(DMEM_WR), .PC(PC), .PHASE(PHASE), .STALL_CYCLE(STALL_CYCLE),
    .BUSY_INSTR(BUSY_INSTR));
